// ==== core/qdec_host.v ====
// Host sequencer that drives a serial flash over single, dual and quad lines.
`timescale 1ns/1ns
`include "qdec_regs.vh"
module qdec_host (
  input wire clock,
  input wire resetn,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [7:0] cmd_opcode,
  input wire [23:0] cmd_addr,
  input wire [3:0] cmd_dummy,
  input wire [7:0] continuous_read_mode_byte,
  input wire cmd_bypass,
  input wire [15:0] cmd_rd_len,
  output reg cmd_done,
  output reg cmd_err,
  input wire wr_valid,
  output wire wr_ready,
  input wire [7:0] wr_byte,
  input wire wr_last,
  output reg rd_valid,
  output reg [7:0] rd_byte,
  output reg qpi_active,
  output reg [7:0] read_param_byte,
  output reg flash_cs_n,
  output reg flash_sclk,
  input wire [3:0] io_in,
  output reg [3:0] io_out,
  output reg [3:0] io_oe
);
  localparam S_IDLE = 4'h0;
  localparam S_OPC = 4'h1;
  localparam S_ADDR = 4'h2;
  localparam S_MODE = 4'h3;
  localparam S_DUM = 4'h4;
  localparam S_WFETCH = 4'h5;
  localparam S_WDATA = 4'h6;
  localparam S_RDATA = 4'h7;
  localparam S_END = 4'h8;

  // ========================================================================
  // Decoding helpers.

  // Command format for an opcode in single-wire or four-wire command mode.
  function [11:0] fmt_of;
    input [7:0] op;
    input qpi;
    reg [11:0] f;
    begin
      f = 12'h000;
      if (qpi) begin
        case (op)
          `QD_OP_WREN, `QD_OP_VWREN, `QD_OP_WRDI, `QD_OP_CE1, `QD_OP_CE2,
          `QD_OP_SUSP, `QD_OP_RESM, `QD_OP_PD, `QD_OP_QEXIT,
          `QD_OP_RSTEN, `QD_OP_RST: f = `QD_FK; // RL2 RL3
          `QD_OP_RS1, `QD_OP_RS2, `QD_OP_RS3,
          `QD_OP_JEDEC: f = `QD_FK | `QD_FR; // RL2
          `QD_OP_WS1, `QD_OP_WS2, `QD_OP_WS3,
          `QD_OP_SETP: f = `QD_FK | `QD_FW; // RL2 RL4
          `QD_OP_RPDID, `QD_OP_MFID: f = `QD_FK | `QD_FA | `QD_FR;
          `QD_OP_PP: f = `QD_FK | `QD_FA | `QD_FW; // RL3
          `QD_OP_SE, `QD_OP_BE32, `QD_OP_BE64: f = `QD_FK | `QD_FA; // RL3
          `QD_OP_FR, `QD_OP_WRAPRD: f = `QD_FK | `QD_FA | `QD_FP | `QD_FR;
          `QD_OP_EBIO: f = `QD_FK | `QD_FA | `QD_FM | `QD_FP | `QD_FR; // RL4
          `QD_OP_DTR1, `QD_OP_DTRWR: f = `QD_FK | `QD_FA | `QD_FT | `QD_FR;
          `QD_OP_DTR4: f = `QD_FK | `QD_FA | `QD_FM | `QD_FT | `QD_FR; // RL19
          default: f = 12'h000;
        endcase
        if (f != 12'h000) begin
          f = f | `QD_FA4 | `QD_FD4; // RL1
        end
      end else begin
        case (op)
          `QD_OP_WREN, `QD_OP_VWREN, `QD_OP_WRDI, `QD_OP_CE1, `QD_OP_CE2,
          `QD_OP_SUSP, `QD_OP_RESM, `QD_OP_PD, `QD_OP_QENTER,
          `QD_OP_RSTEN, `QD_OP_RST: f = `QD_FK;
          `QD_OP_RS1, `QD_OP_RS2, `QD_OP_RS3, `QD_OP_JEDEC: f = `QD_FK | `QD_FR;
          `QD_OP_WS1, `QD_OP_WS2, `QD_OP_WS3: f = `QD_FK | `QD_FW;
          `QD_OP_RPDID, `QD_OP_MFID, `QD_OP_READ: f = `QD_FK | `QD_FA | `QD_FR;
          `QD_OP_PP: f = `QD_FK | `QD_FA | `QD_FW;
          `QD_OP_QPP: f = `QD_FK | `QD_FA | `QD_FW | `QD_FD4;
          `QD_OP_SE, `QD_OP_BE32, `QD_OP_BE64: f = `QD_FK | `QD_FA;
          `QD_OP_FR, `QD_OP_SFDP: f = `QD_FK | `QD_FA | `QD_FR;
          `QD_OP_FR2: f = `QD_FK | `QD_FA | `QD_FR | `QD_FD2;
          `QD_OP_FR4: f = `QD_FK | `QD_FA | `QD_FR | `QD_FD4;
          `QD_OP_BBIO: f = `QD_FK | `QD_FA | `QD_FA2 | `QD_FM | `QD_FR |
            `QD_FD2; // RL12
          `QD_OP_EBIO, `QD_OP_E7IO: f = `QD_FK | `QD_FA | `QD_FA4 | `QD_FM |
            `QD_FR | `QD_FD4; // RL13
          `QD_OP_SETWRAP: f = `QD_FK | `QD_FW | `QD_FD4;
          `QD_OP_SECER: f = `QD_FK | `QD_FA | `QD_FS; // RL11
          `QD_OP_SECPG: f = `QD_FK | `QD_FA | `QD_FW | `QD_FS; // RL11
          `QD_OP_SECRD: f = `QD_FK | `QD_FA | `QD_FR | `QD_FS; // RL11
          `QD_OP_DTR1: f = `QD_FK | `QD_FA | `QD_FT | `QD_FR; // RL18
          `QD_OP_DTR2: f = `QD_FK | `QD_FA | `QD_FA2 | `QD_FM | `QD_FT |
            `QD_FR | `QD_FD2; // RL18
          `QD_OP_DTR4: f = `QD_FK | `QD_FA | `QD_FA4 | `QD_FM | `QD_FT |
            `QD_FR | `QD_FD4; // RL18
          default: f = 12'h000;
        endcase
      end
      fmt_of = f;
    end
  endfunction

  // Pin values for the top four bits of a shift register, MSB first.
  function [3:0] lane_out;
    input [3:0] top;
    input [1:0] lg;
    begin
      case (lg)
        `QD_LG1: lane_out = {3'h0, top[3]};
        `QD_LG2: lane_out = {2'h0, top[3], top[2]}; // RL12
        default: lane_out = top; // RL13 RL14
      endcase
    end
  endfunction

  // Output enables for a lane count.
  function [3:0] lane_oe;
    input [1:0] lg;
    begin
      case (lg)
        `QD_LG1: lane_oe = 4'h1;
        `QD_LG2: lane_oe = 4'h3;
        default: lane_oe = 4'hF;
      endcase
    end
  endfunction

  // Number of bits moved per step for a lane count.
  function [5:0] lanes_of;
    input [1:0] lg;
    begin
      case (lg)
        `QD_LG1: lanes_of = 6'h01;
        `QD_LG2: lanes_of = 6'h02;
        default: lanes_of = 6'h04;
      endcase
    end
  endfunction

  // Phase that follows the current one.
  function [3:0] next_ph;
    input [3:0] cur;
    input [11:0] f;
    input dum_nz;
    input wdone;
    reg [3:0] data_ph;
    begin
      data_ph = f[`QD_F_WR] ? S_WFETCH : (f[`QD_F_RD] ? S_RDATA : S_END);
      case (cur)
        S_OPC: next_ph = f[`QD_F_ADDR] ? S_ADDR : data_ph;
        S_ADDR: next_ph = f[`QD_F_MODE] ? S_MODE :
          (dum_nz ? S_DUM : data_ph); // RL4
        S_MODE: next_ph = dum_nz ? S_DUM : data_ph;
        S_DUM: next_ph = data_ph;
        S_WDATA: next_ph = wdone ? S_END : S_WFETCH;
        default: next_ph = S_END;
      endcase
    end
  endfunction

  // ========================================================================
  // Reset release, divider and input synchroniser.
  reg rst_meta_reg;
  reg rst_n_reg;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  reg run_reg;
  wire edge_tick;
  wire mid_tick;
  wire [3:0] io_sync;
  qdec_sclk_div u_div (
    .clock(clock),
    .rst_n(rst_n_reg),
    .run(run_reg),
    .edge_tick(edge_tick),
    .mid_tick(mid_tick)
  );
  qdec_io_sync u_sync (
    .clock(clock),
    .rst_n(rst_n_reg),
    .io_in(io_in),
    .io_sync(io_sync)
  );

  // ========================================================================
  // Sequencer state.
  reg [3:0] state_reg;
  reg [11:0] fmt_reg;
  reg [7:0] op_reg;
  reg [23:0] addr_reg;
  reg [7:0] mode_reg;
  reg [3:0] dum_reg;
  reg [31:0] sh_reg;
  reg [5:0] cnt_reg;
  reg [1:0] lg_reg;
  reg hold_reg;
  reg [15:0] rd_left_reg;
  reg [7:0] rd_sh_reg;
  reg [3:0] rd_bits_reg;
  reg [8:0] wr_cnt_reg;
  reg wr_last_reg;
  reg [7:0] param_cap_reg;
  reg rst_armed_reg;

  wire [11:0] fmt_new = fmt_of(cmd_opcode, qpi_active);
  wire sec_ok = (cmd_addr[`QD_SEC_TOP] == 8'h00) &&
    (cmd_addr[`QD_SEC_AREA] >= `QD_SEC_MIN) &&
    (cmd_addr[`QD_SEC_AREA] <= `QD_SEC_MAX) &&
    (cmd_addr[`QD_SEC_GAP] == 2'h0); // RL11
  wire wdone = wr_last_reg || (wr_cnt_reg == `QD_PAGE_BYTES); // RL8
  wire [3:0] tgt = next_ph(state_reg, fmt_reg, dum_reg != 4'h0, wdone);
  wire dtr_ph = fmt_reg[`QD_F_DTR] && ((state_reg == S_ADDR) ||
    (state_reg == S_MODE) || (state_reg == S_RDATA)); // RL18 RL19
  wire fall = edge_tick && flash_sclk;
  wire rise = edge_tick && !flash_sclk;
  wire dmid = mid_tick && !hold_reg;
  wire out_ph = (state_reg == S_OPC) || (state_reg == S_ADDR) ||
    (state_reg == S_MODE) || (state_reg == S_DUM) || (state_reg == S_WDATA);
  wire step = out_ph && (dtr_ph ? dmid : fall);
  wire samp = (state_reg == S_RDATA) && (dtr_ph ? dmid : rise);
  wire [5:0] lanes_n = lanes_of(lg_reg);
  wire [31:0] sh_shift = sh_reg << lanes_n;
  wire [7:0] rd_shift = (lg_reg == `QD_LG1) ? {rd_sh_reg[6:0], io_sync[1]} :
    (lg_reg == `QD_LG2) ? {rd_sh_reg[5:0], io_sync[1:0]} :
    {rd_sh_reg[3:0], io_sync[3:0]}; // RL7 RL14
  wire [3:0] rd_bits_next = rd_bits_reg + lanes_n[3:0];

  assign cmd_ready = (state_reg == S_IDLE);
  assign wr_ready = (state_reg == S_WFETCH);

  // Load values for the phase being entered.
  reg [31:0] ld_sh;
  reg [5:0] ld_cnt;
  reg [1:0] ld_lg;
  reg ld_drv;
  always @* begin
    ld_sh = 32'h00000000;
    ld_cnt = `QD_BYTE_BITS;
    ld_lg = fmt_reg[`QD_F_AL];
    ld_drv = 1'b0;
    case (tgt)
      S_ADDR: begin
        ld_sh = {addr_reg, 8'h00}; // RL12 RL13
        ld_cnt = `QD_ADDR_BITS;
        ld_drv = 1'b1;
      end
      S_MODE: begin
        ld_sh = {mode_reg, 24'h000000};
        ld_drv = 1'b1;
      end
      S_DUM: begin
        ld_cnt = {2'h0, dum_reg};
        ld_lg = `QD_LG1;
      end
      default: ld_lg = fmt_reg[`QD_F_DL];
    endcase
  end

  // Main sequencer: commands, phases, serial clock and pins.
  always @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= S_IDLE;
      fmt_reg <= 12'h000;
      op_reg <= 8'h00;
      addr_reg <= 24'h000000;
      mode_reg <= 8'h00;
      dum_reg <= 4'h0;
      sh_reg <= 32'h00000000;
      cnt_reg <= 6'h00;
      lg_reg <= `QD_LG1;
      hold_reg <= 1'b0;
      rd_left_reg <= 16'h0000;
      rd_sh_reg <= 8'h00;
      rd_bits_reg <= 4'h0;
      wr_cnt_reg <= 9'h000;
      wr_last_reg <= 1'b0;
      param_cap_reg <= 8'h00;
      rst_armed_reg <= 1'b0;
      run_reg <= 1'b0;
      cmd_done <= 1'b0;
      cmd_err <= 1'b0;
      rd_valid <= 1'b0;
      rd_byte <= 8'h00;
      qpi_active <= 1'b0;
      read_param_byte <= `QD_PARAM_RST;
      flash_cs_n <= 1'b1;
      flash_sclk <= 1'b0;
      io_out <= 4'h0;
      io_oe <= 4'h0;
    end else begin
      cmd_done <= 1'b0;
      cmd_err <= 1'b0;
      rd_valid <= 1'b0;
      if (edge_tick) begin
        flash_sclk <= ~flash_sclk;
        hold_reg <= 1'b0;
      end
      case (state_reg)
        S_IDLE: begin
          if (cmd_valid) begin
            if (!fmt_new[`QD_F_KNOWN] || (fmt_new[`QD_F_SEC] && !sec_ok)) begin
              cmd_err <= 1'b1; // RL11
            end else begin
              fmt_reg <= fmt_new;
              op_reg <= cmd_opcode;
              addr_reg <= cmd_addr;
              mode_reg <= (fmt_new[`QD_F_DTR] && !cmd_bypass) ?
                {`QD_MODE_HI, continuous_read_mode_byte[3:0]} :
                continuous_read_mode_byte; // RL20
              dum_reg <= !fmt_new[`QD_F_RD] ? 4'h0 : fmt_new[`QD_F_PDUM] ?
                read_param_byte[`QD_PARAM_DUM] : cmd_dummy; // RL3 RL4
              rd_left_reg <= (cmd_rd_len == 16'h0000) ? 16'h0001 : cmd_rd_len;
              rd_bits_reg <= 4'h0;
              wr_cnt_reg <= 9'h000;
              wr_last_reg <= 1'b0;
              sh_reg <= {cmd_opcode, 24'h000000}; // RL7
              cnt_reg <= `QD_BYTE_BITS;
              lg_reg <= qpi_active ? `QD_LG4 : `QD_LG1; // RL1 RL18
              io_out <= lane_out(cmd_opcode[7:4], qpi_active ?
                `QD_LG4 : `QD_LG1); // RL1
              io_oe <= lane_oe(qpi_active ? `QD_LG4 : `QD_LG1);
              flash_cs_n <= 1'b0;
              run_reg <= 1'b1;
              state_reg <= S_OPC;
            end
          end
        end
        S_WFETCH: begin
          if (wr_valid) begin
            sh_reg <= {wr_byte, 24'h000000}; // RL14
            cnt_reg <= `QD_BYTE_BITS;
            lg_reg <= fmt_reg[`QD_F_DL];
            io_out <= lane_out(wr_byte[7:4], fmt_reg[`QD_F_DL]);
            io_oe <= lane_oe(fmt_reg[`QD_F_DL]);
            wr_cnt_reg <= wr_cnt_reg + 9'h001; // RL8
            wr_last_reg <= wr_last;
            if (wr_cnt_reg == 9'h000) begin
              param_cap_reg <= wr_byte;
            end
            run_reg <= 1'b1;
            state_reg <= S_WDATA;
          end
        end
        S_RDATA: begin
          if (samp) begin
            rd_sh_reg <= rd_shift;
            rd_bits_reg <= rd_bits_next;
            if (rd_bits_next == 4'h8) begin
              rd_bits_reg <= 4'h0;
              rd_valid <= 1'b1;
              rd_byte <= rd_shift;
              rd_left_reg <= rd_left_reg - 16'h0001;
              if (rd_left_reg == 16'h0001) begin
                state_reg <= S_END;
              end
            end
          end
        end
        S_END: begin
          // Select rises only with the serial clock low.
          if (!flash_sclk) begin
            flash_cs_n <= 1'b1;
            run_reg <= 1'b0;
            io_oe <= 4'h0;
            cmd_done <= 1'b1;
            state_reg <= S_IDLE;
            rst_armed_reg <= (op_reg == `QD_OP_RSTEN);
            if (op_reg == `QD_OP_QENTER && !qpi_active) begin
              qpi_active <= 1'b1;
            end
            if (op_reg == `QD_OP_QEXIT && qpi_active) begin
              qpi_active <= 1'b0; // RL3
            end
            if (op_reg == `QD_OP_RST && rst_armed_reg) begin
              qpi_active <= 1'b0; // RL3
              read_param_byte <= `QD_PARAM_RST;
            end
            if (op_reg == `QD_OP_SETP && wr_cnt_reg != 9'h000) begin
              read_param_byte <= param_cap_reg; // RL4
            end
          end
        end
        default: begin
          if (step) begin
            if (cnt_reg > lanes_n) begin
              sh_reg <= sh_shift;
              cnt_reg <= cnt_reg - lanes_n;
              io_out <= lane_out(sh_shift[31:28], lg_reg); // RL1 RL13
            end else begin
              sh_reg <= ld_sh;
              cnt_reg <= ld_cnt;
              lg_reg <= ld_lg;
              io_out <= lane_out(ld_sh[31:28], ld_lg);
              io_oe <= ld_drv ? lane_oe(ld_lg) : 4'h0;
              hold_reg <= 1'b1;
              rd_sh_reg <= 8'h00;
              if (tgt == S_WFETCH) begin
                run_reg <= 1'b0;
              end
              state_reg <= tgt;
            end
          end
        end
      endcase
    end
  end
endmodule

// ==== core/qdec_regs.vh ====
// Constants for the serial flash host sequencer: opcodes, formats, timing.
// How it works
// RL1: Four-wire mode moves four bits per clock; opcode upper nibble first.
// RL2: Four-wire write enable, volatile enable, disable, status reads and writes.
// RL3: Four-wire erase, suspend, resume, power-down, exit, reset, program, erase.
// RL4: Four-wire reads take address, mode or dummy, then data; dummy from param. The code does this for 0Bh, 0Ch, EBh only; others use cmd_dummy.
// RL5: Device takes wrapped burst length from low param nibble.
// RL6: Device repeats status and identification bytes until select rises.
// RL7: Bytes move most significant bit first on one, two or four lines.
// RL8: Host sends one to 256 data bytes after program address.
// RL9: Device wraps program byte pointer within the page past 256.
// RL10: Device lets status one write carry a second byte.
// RL11: Security areas use top byte zero, bits 15..12 one to three.
// RL12: Dual address puts even bits on IO0, odd bits on IO1.
// RL13: Quad address puts bit n on IO(n mod 4), A23 first.
// RL14: Quad data sends upper nibble then lower nibble on IO3..IO0.
// RL15: Device takes wrap bits from IO0..IO2 on seventh clock.
// RL16: Device gives four undefined clocks after mode byte in quad read.
// RL17: Device gives two undefined clocks after mode byte in word read.
// RL18: Double-rate single-wire reads 0Dh, BDh, EDh: eight-clock opcode.
// RL19: Double-rate four-wire reads 0Eh, 0Dh, EDh: two-clock opcode.
// RL20: Host sends Fxh mode byte in double-rate reads unless bypassing.
// RL21: Device refuses program, erase, status write without write enable.
// RL22: Device stays four-wire only with quad enable bit set.
// RL23: Device ignores unknown opcodes until select toggles.
// RL24: Raising select returns the device decoder to opcode wait.
`ifndef QDEC_REGS_VH
`define QDEC_REGS_VH

// ==========================================================================
// Opcodes.
`define QD_OP_WREN 8'h06
`define QD_OP_VWREN 8'h50
`define QD_OP_WRDI 8'h04
`define QD_OP_RS1 8'h05
`define QD_OP_RS2 8'h35
`define QD_OP_RS3 8'h15
`define QD_OP_WS1 8'h01
`define QD_OP_WS2 8'h31
`define QD_OP_WS3 8'h11
`define QD_OP_CE1 8'hC7
`define QD_OP_CE2 8'h60
`define QD_OP_SUSP 8'h75
`define QD_OP_RESM 8'h7A
`define QD_OP_PD 8'hB9
`define QD_OP_SETP 8'hC0
`define QD_OP_RPDID 8'hAB
`define QD_OP_MFID 8'h90
`define QD_OP_JEDEC 8'h9F
`define QD_OP_QENTER 8'h38
`define QD_OP_QEXIT 8'hFF
`define QD_OP_RSTEN 8'h66
`define QD_OP_RST 8'h99
`define QD_OP_PP 8'h02
`define QD_OP_QPP 8'h32
`define QD_OP_SE 8'h20
`define QD_OP_BE32 8'h52
`define QD_OP_BE64 8'hD8
`define QD_OP_READ 8'h03
`define QD_OP_FR 8'h0B
`define QD_OP_FR2 8'h3B
`define QD_OP_FR4 8'h6B
`define QD_OP_SFDP 8'h5A
`define QD_OP_WRAPRD 8'h0C
`define QD_OP_BBIO 8'hBB
`define QD_OP_EBIO 8'hEB
`define QD_OP_E7IO 8'hE7
`define QD_OP_SETWRAP 8'h77
`define QD_OP_SECER 8'h44
`define QD_OP_SECPG 8'h42
`define QD_OP_SECRD 8'h48
`define QD_OP_DTR1 8'h0D
`define QD_OP_DTR2 8'hBD
`define QD_OP_DTR4 8'hED
`define QD_OP_DTRWR 8'h0E

// ==========================================================================
// Command format word: one bit per flag, OR-ed together.
`define QD_FK 12'h001
`define QD_FA 12'h002
`define QD_FA2 12'h004
`define QD_FA4 12'h008
`define QD_FM 12'h010
`define QD_FP 12'h020
`define QD_FW 12'h040
`define QD_FR 12'h080
`define QD_FD2 12'h100
`define QD_FD4 12'h200
`define QD_FT 12'h400
`define QD_FS 12'h800
`define QD_F_KNOWN 0
`define QD_F_ADDR 1
`define QD_F_AL 3:2
`define QD_F_MODE 4
`define QD_F_PDUM 5
`define QD_F_WR 6
`define QD_F_RD 7
`define QD_F_DL 9:8
`define QD_F_DTR 10
`define QD_F_SEC 11

// ==========================================================================
// Lane codes, field layouts and reset values.
`define QD_LG1 2'h0
`define QD_LG2 2'h1
`define QD_LG4 2'h2
`define QD_ADDR_BITS 6'h18
`define QD_BYTE_BITS 6'h08
`define QD_PAGE_BYTES 9'h100
`define QD_SEC_TOP 23:16
`define QD_SEC_AREA 15:12
`define QD_SEC_GAP 11:10
`define QD_SEC_MIN 4'h1
`define QD_SEC_MAX 4'h3
`define QD_PARAM_DUM 7:4
`define QD_MODE_HI 4'hF
`define QD_PARAM_RST 8'h00

// ==========================================================================
// Serial clock: half period and mid point in system clocks.
`define QD_SCLK_HALF 4'h8
`define QD_SCLK_MID 4'h4

`endif

// ==== core/qdec_sclk_div.v ====
// Divider giving edge and mid-point enables for the serial clock.
`timescale 1ns/1ns
`include "qdec_regs.vh"
module qdec_sclk_div (
  input wire clock,
  input wire rst_n,
  input wire run,
  output wire edge_tick,
  output wire mid_tick
);
  reg [3:0] cnt_reg;

  // Count half periods while running; restart cleanly after a stall.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
    end else if (!run || edge_tick) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  // One-cycle enables at the end and the middle of each half period.
  assign edge_tick = run && (cnt_reg == `QD_SCLK_HALF - 4'h1);
  assign mid_tick = run && (cnt_reg == `QD_SCLK_MID - 4'h1);
endmodule

// ==== core/qdec_io_sync.v ====
// Two-stage synchroniser for the four IO input lines.
`timescale 1ns/1ns
module qdec_io_sync (
  input wire clock,
  input wire rst_n,
  input wire [3:0] io_in,
  output wire [3:0] io_sync
);
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : lane
      reg meta_reg;
      reg sync_reg;
      // The first stage feeds only the second stage.
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= io_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign io_sync[i] = sync_reg;
    end
  endgenerate
endmodule

// ==== test/qdec_host_sva.sv ====
// Checker of the serial flash host sequencer port behaviour.
`timescale 1ns/1ns
module qdec_host_chk (
  input wire clock,
  input wire resetn,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [7:0] cmd_opcode,
  input wire [23:0] cmd_addr,
  input wire cmd_done,
  input wire cmd_err,
  input wire rd_valid,
  input wire wr_ready,
  input wire qpi_active,
  input wire flash_cs_n,
  input wire flash_sclk,
  input wire [3:0] io_out,
  input wire [3:0] io_oe
);
  wire take;
  wire sec_op;
  wire sec_bad;

  // ==========================================================================
  // Helper terms for a taken command and a malformed security address.
  assign take = cmd_valid && cmd_ready;
  assign sec_op = cmd_opcode == 8'h42 || cmd_opcode == 8'h44 ||
                  cmd_opcode == 8'h48;
  assign sec_bad = cmd_addr[23:16] != 8'h00 || cmd_addr[15:12] == 4'h0 ||
                   cmd_addr[15:12] > 4'h3 || cmd_addr[11:10] != 2'b00;

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  // ==========================================================================
  // Framing, refusals and the first opcode bits on the wires.
  idle_clk_a: assert property (flash_cs_n |-> !flash_sclk)
    else $error("serial clock moved while deselected");
  done_sel_a: assert property (cmd_done |-> flash_cs_n)
    else $error("done flagged while still selected");
  idle_release_a: assert property (flash_cs_n && $past(flash_cs_n) |->
    io_oe == 4'h0)
    else $error("lines driven while deselected");
  refuse_sel_a: assert property (cmd_err |-> flash_cs_n && !cmd_done)
    else $error("refused command selected the device");
  err_pulse_a: assert property (cmd_err |=> !cmd_err)
    else $error("error flag longer than one cycle");
  take_sel_a: assert property (take |=> !flash_cs_n || cmd_err)
    else $error("taken command neither started nor refused");
  quad_first_a: assert property ($fell(flash_cs_n) && qpi_active |->
    io_oe == 4'hF && io_out == $past(cmd_opcode[7:4]))
    else $error("four-wire opcode did not start with upper nibble");
  single_first_a: assert property ($fell(flash_cs_n) &&
    !qpi_active |-> io_oe == 4'h1 && io_out[0] == $past(cmd_opcode[7]))
    else $error("single-wire opcode did not start with its top bit");
  sec_addr_a: assert property (take && sec_op && sec_bad |=>
    cmd_err)
    else $error("bad security address not refused");
  wait_clk_a: assert property (wr_ready |-> !flash_sclk && !flash_cs_n)
    else $error("serial clock ran while waiting for a write byte");

  // Main scenarios reached.
  cover property (rd_valid && qpi_active);
  cover property (cmd_err);
  cover property ($fell(qpi_active));
endmodule

bind qdec_host qdec_host_chk u_qdec_host_chk (.*);

// ==== test/qdec_flash_model.sv ====
// Behavioural serial flash device answering the host sequencer.
`timescale 1ns/1ns
module qdec_flash_model #(
  parameter logic [7:0] STATUS_VAL = 8'h5C
) (
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] io,
  output logic [3:0] dq,
  output logic [3:0] dq_oe,
  output logic [7:0] last_op
);
  logic quad = 1'b0;
  logic rd = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [2:0] k = 3'h0;
  int n = 0;

  initial begin
    dq = 4'h0;
    dq_oe = 4'h0;
    last_op = 8'h00;
  end

  // Select high restarts decoding; rising clock shifts in, falling shifts out.
  always @(posedge sclk or negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      dq_oe = 4'h0;
      rd = 1'b0;
      n = 0;
      k = 3'h0;
    end else if (sclk && n < 8) begin
      sh = quad ? {sh[3:0], io} : {sh[6:0], io[0]};
      n = n + (quad ? 4 : 1);
      if (n == 8) begin
        last_op = sh;
        rd = sh == 8'h05;
        if (sh == 8'h38) quad = 1'b1;
        if (sh == 8'hFF) quad = 1'b0;
      end
    end else if (!sclk && rd) begin
      if (quad) begin
        dq = k[0] ? STATUS_VAL[3:0] : STATUS_VAL[7:4];
        dq_oe = 4'hF;
      end else begin
        dq = {2'b00, STATUS_VAL[3'h7 - k], 1'b0};
        dq_oe = 4'h2;
      end
      k = k + 3'h1;
    end
  end
endmodule

// ==== test/tb_qdec_host.sv ====
// Self-checking bench of the serial flash host sequencer with a device model.
`timescale 1ns/1ns
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  miscompares++; $display("Error at %0t: got %h expected %h", $time, \
  got, exp); end end
module tb_qdec_host;
  localparam logic [7:0] STAT = 8'h5C;
  logic clock = 0, resetn = 0, cmd_valid = 0, cmd_bypass = 0, err;
  logic [7:0] cmd_opcode = 0, mode_byte = 0, wr_byte = 0, pb, last_op, ex;
  logic [23:0] cmd_addr = 0;
  logic [3:0] cmd_dummy = 0, junk = 0, dq, dq_oe, io_in, io_out, io_oe;
  logic [15:0] cmd_rd_len = 1;
  logic cmd_ready, cmd_done, cmd_err, rd_valid, qpi_active, wr_ready;
  logic flash_cs_n, flash_sclk, wr_valid = 0;
  logic [7:0] rd_byte, read_param_byte;
  logic [7:0] expq[$];
  logic [7:0] qops[7] = '{8'h06, 8'h50, 8'h04, 8'hC7, 8'h60, 8'h75, 8'h7A};
  int miscompares = 0, tests_run = 0;

  // ==========================================================================
  // Clock, wire resolution and the two instances.
  always #20 clock = ~clock;
  always @(posedge clock) junk <= ~junk;
  // Offers a write byte in the same cycle the host asks for it.
  always @(posedge clock) #1 wr_valid = wr_ready === 1'b1;
  // Undriven lines show a pattern that flips every cycle.
  assign io_in = (io_oe & io_out) | (~io_oe & dq_oe & dq) |
                 (~io_oe & ~dq_oe & junk);

  qdec_host u_qdec_host (.clock(clock), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode),
    .cmd_addr(cmd_addr), .cmd_dummy(cmd_dummy),
    .continuous_read_mode_byte(mode_byte), .cmd_bypass(cmd_bypass),
    .cmd_rd_len(cmd_rd_len), .cmd_done(cmd_done), .cmd_err(cmd_err),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_byte(wr_byte),
    .wr_last(1'b1), .rd_valid(rd_valid), .rd_byte(rd_byte),
    .qpi_active(qpi_active), .read_param_byte(read_param_byte),
    .flash_cs_n(flash_cs_n), .flash_sclk(flash_sclk), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe));

  qdec_flash_model #(.STATUS_VAL(STAT)) u_qdec_flash_model (
    .cs_n(flash_cs_n), .sclk(flash_sclk), .io(io_in), .dq(dq),
    .dq_oe(dq_oe), .last_op(last_op));

  // Every gathered read byte is matched against the oldest expectation.
  always @(posedge clock) begin
    if (rd_valid === 1'b1) begin
      `CHK(expq.size() != 0, 1'b1)
      if (expq.size() != 0) begin
        ex = expq.pop_front();
        `CHK(rd_byte, ex)
      end
    end
  end

  // Issues one command and waits, bounded, for its end or refusal.
  task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                     input logic [15:0] n);
    int i;
    do @(posedge clock) #1; while (cmd_ready !== 1'b1);
    cmd_opcode = op;
    cmd_addr = a;
    cmd_rd_len = n;
    cmd_dummy = 4'($urandom);
    mode_byte = 8'($urandom);
    cmd_bypass = 1'($urandom);
    cmd_valid = 1'b1;
    @(posedge clock) #1;
    cmd_valid = 1'b0;
    for (i = 0; i < 9000 && cmd_done !== 1'b1 && cmd_err !== 1'b1; i++)
      @(posedge clock) #1;
    err = cmd_err;
    `CHK({i < 9000, flash_cs_n}, 2'b11)
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence: single-wire work, four-wire entry, table, reads, exit.
  initial begin
    void'($urandom(32'h643C8D34));
    repeat (10) @(posedge clock);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    `CHK({flash_cs_n, flash_sclk, io_oe, qpi_active}, 7'h40)
    `CHK(read_param_byte, 8'h00)
    repeat (2) expq.push_back(STAT);
    cmd(8'h05, 24'h0, 16'h2);
    `CHK({err, last_op}, {1'b0, 8'h05})
    cmd(8'h42, 24'h004000, 16'h1);
    `CHK(err, 1'b1)
    cmd(8'h44, 24'h013000, 16'h1);
    `CHK(err, 1'b1)
    cmd(8'h44, 24'h003000, 16'h1);
    `CHK({err, last_op}, {1'b0, 8'h44})
    cmd(8'h38, 24'h0, 16'h1);
    `CHK({qpi_active, last_op}, 9'h138)
    foreach (qops[j]) begin
      cmd(qops[j], 24'($urandom), 16'h1);
      `CHK({err, last_op}, {1'b0, qops[j]})
    end
    pb = 8'($urandom);
    wr_byte = pb;
    cmd(8'hC0, 24'h0, 16'h1);
    `CHK({read_param_byte, last_op}, {pb, 8'hC0})
    repeat (3) expq.push_back(STAT);
    cmd(8'h05, 24'h0, 16'h3);
    `CHK({err, qpi_active}, 2'b01)
    cmd(8'hA3, 24'h0, 16'h1);
    `CHK({err, last_op}, {1'b1, 8'h05})
    cmd(8'hFF, 24'h0, 16'h1);
    `CHK({qpi_active, last_op}, 9'h0FF)
    `CHK(expq.size() == 0, 1'b1)
    print_verdict();
  end

  // Watchdog: the sequence needs about 1500 cycles, this allows 50000.
  initial begin
    #2000000;
    miscompares++;
    print_verdict();
  end
endmodule
